// ==== inc/flash_host_consts.vh ====
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
// ---------------------------------------------------------------
// register offsets of the controller's own port
// ---------------------------------------------------------------
`define REG_ADDR 4'h0
`define REG_WDATA 4'h1
`define REG_CTRL 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
`define REG_PDATA 4'h5
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 3
`define CTRL_WORD_BIT 4
`define CTRL_ACC_BIT 5
`define CTRL_RESET_BIT 6
`define CTRL_RESET 7'h00
// ---------------------------------------------------------------
// operation codes
// ---------------------------------------------------------------
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_PROG4 3'h2
`define OP_PROG2 3'h3
`define OP_IDREAD 3'h4
`define OP_HWRESET 3'h5
// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define STAT_BUSY_BIT 0
`define STAT_RB_BIT 1
`define STAT_DONE_BIT 2
// ---------------------------------------------------------------
// bus cycle timing (ns) and clock period (ns)
// ---------------------------------------------------------------
`define CLK_NS 8
`define ACCESS_NS 70
`define SETUP_NS 35
`define RESET_PULSE_NS 500
`define RESET_REC_NS 50
`define RESET_READY_NS 20000
`endif

// ==== logic/cycle_timer.v ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// down counter that marks the end of a bus phase
// ---------------------------------------------------------------
module cycle_timer (
  input wire clk_sys,
  input wire rstn,
  input wire load,
  input wire [15:0] count,
  output reg expired
);
  reg [15:0] cnt_q; // cycles still to run

  // load wins over counting so a new phase restarts cleanly
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
      expired <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      expired <= 1'b0;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
      expired <= (cnt_q == 16'h0001);
    end else begin
      expired <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== logic/flash_host.v ====
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"
module flash_host #(
  parameter ACCESS_NS = `ACCESS_NS,
  parameter SETUP_NS = `SETUP_NS,
  parameter RESET_PULSE_NS = `RESET_PULSE_NS,
  parameter RESET_REC_NS = `RESET_REC_NS,
  parameter RESET_READY_NS = `RESET_READY_NS
) (
  input wire clk_sys,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg [19:0] flash_addr,
  input wire [15:0] data_pins_in,
  output reg [15:0] data_pins_out,
  output reg [15:0] data_pins_oe,
  output reg chip_sel_n,
  output reg out_en_n,
  output reg wr_strobe_n,
  output reg hw_reset_n,
  output reg width_word,
  output reg protect_accelerate_pin,
  input wire ready_busy_n
);
  // ---------------------------------------------------------------
  // derived cycle counts
  // ---------------------------------------------------------------
  localparam [15:0] ACC_CYC = (ACCESS_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [15:0] SET_CYC = (SETUP_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [15:0] RP_CYC = (RESET_PULSE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [15:0] RH_CYC = (RESET_REC_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [15:0] RDY_CYC = (RESET_READY_NS + `CLK_NS - 1) / `CLK_NS;
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RD = 3'h1;
  localparam [2:0] S_WR = 3'h2;
  localparam [2:0] S_GAP = 3'h3;
  localparam [2:0] S_RST = 3'h4;
  localparam [2:0] S_RDY = 3'h5;
  localparam [2:0] S_REC = 3'h6;

  reg [2:0] state_q; // sequencer state
  reg [19:0] addr_q; // software address
  reg [15:0] wdata_q; // command data for one write
  reg [15:0] pdata_q; // program data
  reg [6:0] ctrl_q; // control bits
  reg [15:0] rdata_q; // last captured read
  reg done_q; // sticky completion
  reg [2:0] step_q; // write cycle index
  reg [2:0] nsteps_q; // writes in this sequence
  reg load; // timer restart
  reg [15:0] tload; // timer count
  wire tdone; // phase end
  reg [15:0] din_s1_q; // pin sync, first stage
  reg [15:0] din_s2_q; // pin sync, second stage
  reg rb_s1_q; // ready/busy sync, first stage
  reg rb_s2_q; // ready/busy sync, second stage
  wire [2:0] op = ctrl_q[`CTRL_OP_MSB:`CTRL_OP_LSB];

  cycle_timer u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(load),
    .count(tload),
    .expired(tdone)
  );

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // two flops on pins from outside; only the second is read
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      din_s1_q <= data_pins_in;
      din_s2_q <= din_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // unlock-sequence words for the current write step
  // ---------------------------------------------------------------
  // standard program is two unlocks, setup, data; shortened is setup, data
  reg [19:0] seq_addr; // address of this write
  reg [15:0] seq_data; // data of this write
  always @* begin
    seq_addr = addr_q;
    seq_data = wdata_q;
    if (op == `OP_PROG4) begin
      case (step_q)
        3'h0: begin seq_addr = 20'h00555; seq_data = 16'h00AA; end
        3'h1: begin seq_addr = 20'h002AA; seq_data = 16'h0055; end
        3'h2: begin seq_addr = 20'h00555; seq_data = 16'h00A0; end
        default: begin seq_addr = addr_q; seq_data = pdata_q; end
      endcase
    end else if (op == `OP_PROG2) begin
      case (step_q)
        3'h0: begin seq_addr = addr_q; seq_data = 16'h00A0; end
        default: begin seq_addr = addr_q; seq_data = pdata_q; end
      endcase
    end else if (op == `OP_IDREAD) begin
      case (step_q)
        3'h0: begin seq_addr = 20'h00555; seq_data = 16'h00AA; end
        3'h1: begin seq_addr = 20'h002AA; seq_data = 16'h0055; end
        default: begin seq_addr = 20'h00555; seq_data = 16'h0090; end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  // go is a one-shot; it clears itself once the sequencer takes it
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      pdata_q <= 16'h0000;
      ctrl_q <= `CTRL_RESET;
      reg_rdata <= 32'h00000000;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `REG_ADDR: addr_q <= reg_wdata[19:0];
          `REG_WDATA: wdata_q <= reg_wdata[15:0];
          `REG_PDATA: pdata_q <= reg_wdata[15:0];
          `REG_CTRL: ctrl_q <= reg_wdata[6:0];
          default: ;
        endcase
      end
      if (state_q == S_IDLE && ctrl_q[`CTRL_GO_BIT] && !(reg_wr && reg_addr == `REG_CTRL)) begin
        ctrl_q[`CTRL_GO_BIT] <= 1'b0;
      end
      if (reg_rd) begin
        case (reg_addr)
          `REG_ADDR: reg_rdata <= {12'h000, addr_q};
          `REG_WDATA: reg_rdata <= {16'h0000, wdata_q};
          `REG_PDATA: reg_rdata <= {16'h0000, pdata_q};
          `REG_CTRL: reg_rdata <= {25'h0000000, ctrl_q};
          `REG_STATUS: reg_rdata <= {29'h00000000, done_q, rb_s2_q, state_q != S_IDLE};
          `REG_RDATA: reg_rdata <= {16'h0000, rdata_q};
          default: reg_rdata <= 32'h00000000;
        endcase
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus sequencer
  // ---------------------------------------------------------------
  // the device is polled for ready only after a hardware reset: otherwise software watches
  // the ready/busy bit, which allows reads of the other bank
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      step_q <= 3'h0;
      nsteps_q <= 3'h0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
      load <= 1'b0;
      tload <= 16'h0000;
      flash_addr <= 20'h00000;
      data_pins_out <= 16'h0000;
      data_pins_oe <= 16'h0000;
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      hw_reset_n <= 1'b1;
      width_word <= 1'b1;
      protect_accelerate_pin <= 1'b0;
    end else begin
      load <= 1'b0;
      width_word <= ctrl_q[`CTRL_WORD_BIT];
      protect_accelerate_pin <= ctrl_q[`CTRL_ACC_BIT];
      if (reg_wr && reg_addr == `REG_STATUS) begin
        done_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          // idle: deselected with reset high is standby
          chip_sel_n <= 1'b1;
          out_en_n <= 1'b1;
          wr_strobe_n <= 1'b1;
          data_pins_oe <= 16'h0000;
          step_q <= 3'h0;
          if (ctrl_q[`CTRL_GO_BIT]) begin
            if (op == `OP_HWRESET) begin
              hw_reset_n <= 1'b0;
              tload <= RP_CYC;
              load <= 1'b1;
              state_q <= S_RST;
            end else if (op == `OP_READ) begin
              // plain read needs no command full access
              flash_addr <= addr_q;
              chip_sel_n <= 1'b0;
              out_en_n <= 1'b0;
              data_pins_oe <= ctrl_q[`CTRL_WORD_BIT] ? 16'h0000 : 16'h8000;
              data_pins_out[15] <= addr_q[0];
              tload <= ACC_CYC;
              load <= 1'b1;
              state_q <= S_RD;
            end else begin
              // write and program selections are plain write sequences; id-read is three writes then a read
              case (op)
                `OP_PROG4: nsteps_q <= 3'h4;
                `OP_PROG2: nsteps_q <= 3'h2;
                `OP_IDREAD: nsteps_q <= 3'h3;
                default: nsteps_q <= 3'h1;
              endcase
              state_q <= S_GAP;
              tload <= 16'h0001;
              load <= 1'b1;
            end
          end
        end
        S_GAP: begin
          if (tdone && step_q == nsteps_q) begin
            flash_addr <= addr_q;
            out_en_n <= 1'b0;
            data_pins_oe <= ctrl_q[`CTRL_WORD_BIT] ? 16'h0000 : 16'h8000;
            data_pins_out[15] <= addr_q[0];
            tload <= ACC_CYC;
            load <= 1'b1;
            state_q <= S_RD;
          end else if (tdone) begin
            flash_addr <= seq_addr;
            data_pins_out <= seq_data;
            // byte mode drives only the low byte; top pin is address
            data_pins_oe <= ctrl_q[`CTRL_WORD_BIT] ? 16'hFFFF : 16'h00FF;
            if (!ctrl_q[`CTRL_WORD_BIT]) begin
              data_pins_oe[15] <= 1'b1;
              data_pins_out[15] <= seq_addr[0];
            end
            chip_sel_n <= 1'b0;
            wr_strobe_n <= 1'b0;
            out_en_n <= 1'b1;
            tload <= SET_CYC;
            load <= 1'b1;
            state_q <= S_WR;
          end
        end
        S_WR: begin
          if (tdone) begin
            wr_strobe_n <= 1'b1;
            if (step_q + 3'h1 == nsteps_q && op != `OP_IDREAD) begin
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              step_q <= step_q + 3'h1;
              tload <= 16'h0001;
              load <= 1'b1;
              state_q <= S_GAP;
            end
          end
        end
        S_RD: begin
          // pins pass two sync flops before capture, so wait is stretched
          if (tdone) begin
            state_q <= S_REC;
            tload <= 16'h0003;
            load <= 1'b1;
          end
        end
        S_REC: begin
          if (tdone) begin
            if (out_en_n) begin
              state_q <= S_IDLE;
              done_q <= 1'b1;
            end else begin
              // id codes only on the low eight pins
              rdata_q <= (op == `OP_IDREAD) ? {8'h00, din_s2_q[7:0]} :
                ctrl_q[`CTRL_WORD_BIT] ? din_s2_q : {8'h00, din_s2_q[7:0]};
              out_en_n <= 1'b1;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_RST: begin
          if (tdone) begin
            hw_reset_n <= 1'b1;
            tload <= RDY_CYC;
            load <= 1'b1;
            state_q <= S_RDY;
          end
        end
        S_RDY: begin
          // wait for ready after abort then recovery
          if (tdone || (rb_s2_q && !load)) begin
            tload <= RH_CYC;
            load <= 1'b1;
            state_q <= S_REC;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// behavioural flash device with a single bank and one busy flag
// ----
module flash_dev_model #(
  parameter ACC_NS = 60,
  parameter PROG_NS = 400,
  parameter READY_NS = 200,
  parameter [7:0] ID_CODE = 8'h5C // arbitrary value
) (
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] bus,
  input wire logic lsb_in,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_strobe_n,
  input wire logic hw_reset_n,
  input wire logic width_word,
  input wire logic protect_accelerate_pin,
  output wire logic [15:0] dev_out,
  output var logic ready_busy_n
);
  logic [15:0] mem [0:255]; // low corner of the array only
  logic [15:0] drv;
  logic [2:0] st; // unlock sequence position
  logic id_mode;
  time busy_end;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {~i[7:0], i[7:0]};
    st = 3'h0;
    id_mode = 1'b0;
    busy_end = 0;
    drv = 16'h0000;
    ready_busy_n = 1'b1;
  end
  // busy until the running operation's end time
  always #4 ready_busy_n = ($time >= busy_end);
  // read path; released pins toggle so stale data never passes
  always @(chip_sel_n or out_en_n or wr_strobe_n or hw_reset_n or flash_addr or lsb_in
           or width_word or id_mode) begin
    if (!chip_sel_n && !out_en_n && wr_strobe_n && hw_reset_n) begin
      if (id_mode) drv = {~drv[15:8], ID_CODE};
      else if (width_word) drv = mem[flash_addr[7:0]];
      else drv = {~drv[15:8], lsb_in ? mem[flash_addr[7:0]][15:8] : mem[flash_addr[7:0]][7:0]};
    end else begin
      drv = ~drv;
    end
  end
  assign #(ACC_NS) dev_out = drv;
  // command latch, taken as the write strobe rises
  always @(posedge wr_strobe_n) begin
    if (!chip_sel_n && out_en_n && hw_reset_n) begin
      if (bus[7:0] == 8'hF0) begin
        st = 3'h0;
        id_mode = 1'b0;
      end else if (st == 3'h4) begin
        mem[flash_addr[7:0]] = bus;
        busy_end = $time + PROG_NS;
        st = 3'h0;
      end else if (protect_accelerate_pin) begin
        st = (bus[7:0] == 8'hA0) ? 3'h4 : 3'h0;
      end else if (st == 3'h0) begin
        st = (flash_addr[10:0] == 11'h555 && bus[7:0] == 8'hAA) ? 3'h1 : 3'h0;
      end else if (st == 3'h1) begin
        st = (flash_addr[10:0] == 11'h2AA && bus[7:0] == 8'h55) ? 3'h2 : 3'h0;
      end else begin
        id_mode = (flash_addr[10:0] == 11'h555 && bus[7:0] == 8'h90);
        st = (flash_addr[10:0] == 11'h555 && bus[7:0] == 8'hA0) ? 3'h4 : 3'h0;
      end
    end
  end
  // hardware reset aborts and returns to array reads
  always @(negedge hw_reset_n) begin
    st = 3'h0;
    id_mode = 1'b0;
    if (!ready_busy_n) busy_end = $time + READY_NS;
  end
endmodule
`default_nettype wire

// ==== tb/flash_host_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module flash_host_bench;
  localparam [7:0] ID_CODE = 8'h5C; // arbitrary value
  logic clk_sys, rstn, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, s;
  wire logic [31:0] reg_rdata;
  wire logic [19:0] flash_addr;
  wire logic [15:0] data_pins_out, data_pins_oe, dev_out;
  wire logic chip_sel_n, out_en_n, wr_strobe_n, hw_reset_n, width_word;
  wire logic protect_accelerate_pin, ready_busy_n;
  integer err_total, compares, cyc;
  // ----
  // shared data wire: host lanes win where enabled
  // ----
  wire logic [15:0] pins = (data_pins_oe & data_pins_out) | (~data_pins_oe & dev_out);
  flash_host #(.RESET_READY_NS(200)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .data_pins_in(pins),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .hw_reset_n(hw_reset_n),
    .width_word(width_word), .protect_accelerate_pin(protect_accelerate_pin),
    .ready_busy_n(ready_busy_n));
  flash_dev_model #(.ID_CODE(ID_CODE)) u_dev (.flash_addr(flash_addr), .bus(pins),
    .lsb_in(data_pins_out[15]), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n), .hw_reset_n(hw_reset_n), .width_word(width_word),
    .protect_accelerate_pin(protect_accelerate_pin), .dev_out(dev_out),
    .ready_busy_n(ready_busy_n));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ----
  // register port tasks
  // ----
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, output [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // start an operation and poll until it reports done, bounded
  task run(input [2:0] op, input w, input acc);
    integer n;
    logic [31:0] st;
    n = 0;
    st = 32'h0;
    wr(`REG_CTRL, {26'h0, acc, w, op, 1'b1});
    while (st[`STAT_DONE_BIT] !== 1'b1 && n < 500) begin
      rd(`REG_STATUS, st);
      n = n + 1;
    end
    `CHK(st[`STAT_DONE_BIT], 1'b1)
    `CHK(st[`STAT_BUSY_BIT], 1'b0)
    wr(`REG_STATUS, 32'h0);
  endtask
  task rd_arr(input [19:0] a, input w, output [31:0] d);
    wr(`REG_ADDR, {12'h000, a});
    run(`OP_READ, w, 1'b0);
    rd(`REG_RDATA, d);
  endtask
  task finish_test;
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well above the sequence's length
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`REG_STATUS, s);
    `CHK(s[`STAT_RB_BIT], 1'b1)
    rd(4'hF, s);
    `CHK(s, 32'h0000_0000)
    rd_arr(20'h00033, 1'b1, s);
    `CHK(s[15:0], 16'hCC33)
    rd_arr(20'h00000, 1'b0, s);
    `CHK(s[7:0], 8'h00)
    rd_arr(20'h00033, 1'b0, s);
    `CHK(s[15:0], 16'h00CC)
    wr(`REG_ADDR, 32'h40);
    wr(`REG_PDATA, 32'h1234);
    run(`OP_PROG4, 1'b1, 1'b0);
    rd_arr(20'h00040, 1'b1, s);
    `CHK(s[15:0], 16'h1234)
    wr(`REG_ADDR, 32'h41);
    wr(`REG_PDATA, 32'hBEEF);
    run(`OP_PROG2, 1'b1, 1'b1);
    rd_arr(20'h00041, 1'b1, s);
    `CHK(s[15:0], 16'hBEEF)
    wr(`REG_ADDR, 32'h0);
    run(`OP_IDREAD, 1'b1, 1'b0);
    rd(`REG_RDATA, s);
    `CHK(s[7:0], ID_CODE)
    rd_arr(20'h00033, 1'b1, s);
    `CHK(s[7:0], ID_CODE)
    run(`OP_HWRESET, 1'b1, 1'b0);
    rd_arr(20'h00033, 1'b1, s);
    `CHK(s[15:0], 16'hCC33)
    run(`OP_IDREAD, 1'b1, 1'b0);
    wr(`REG_WDATA, 32'hF0);
    run(`OP_WRITE, 1'b1, 1'b0);
    rd_arr(20'h00033, 1'b1, s);
    `CHK(s[15:0], 16'hCC33)
    finish_test;
  end
endmodule
bind flash_host flash_host_chk u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .flash_addr(flash_addr), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
  .hw_reset_n(hw_reset_n), .width_word(width_word),
  .protect_accelerate_pin(protect_accelerate_pin));
`default_nettype wire

// ==== tb/flash_host_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// pin-level checks of the flash host
// ----
module flash_host_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] data_pins_out,
  input wire logic [15:0] data_pins_oe,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_strobe_n,
  input wire logic hw_reset_n,
  input wire logic width_word,
  input wire logic protect_accelerate_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // cycles the device reset pin has been low, saturating
  logic [7:0] low_q;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_q <= 8'h00;
    end else if (hw_reset_n) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hFF) begin
      low_q <= low_q + 8'h01;
    end
  end
  a_read_strobe:
    assert property (!chip_sel_n && !out_en_n |-> wr_strobe_n) else $error("strobe low in read");
  a_write_enable:
    assert property (!wr_strobe_n |-> !chip_sel_n && out_en_n) else $error("bad write levels");
  a_read_lanes:
    assert property (!out_en_n |-> data_pins_oe == (width_word ? 16'h0000 : 16'h8000))
      else $error("host drives data in read");
  a_write_lanes:
    assert property (!wr_strobe_n |-> data_pins_oe == (width_word ? 16'hFFFF : 16'h80FF))
      else $error("wrong lanes in write");
  a_read_hold:
    assert property ($fell(out_en_n) |-> !out_en_n [*8]) else $error("read shorter than access");
  a_read_addr:
    assert property ($fell(out_en_n) |=> $stable(flash_addr) [*7]) else $error("address moved");
  a_write_hold:
    assert property ($fell(wr_strobe_n) |=>
      ($stable(data_pins_out) && $stable(flash_addr) && !wr_strobe_n) [*4])
      else $error("write cycle unstable");
  a_reset_len:
    assert property ($rose(hw_reset_n) |-> low_q >= 8'h3F) else $error("reset pulse short");
  a_reset_rec:
    assert property ($rose(hw_reset_n) |-> out_en_n [*7]) else $error("read in recovery");
  c_byte_read: cover property ($fell(out_en_n) && !width_word);
  c_fast_prog: cover property ($fell(wr_strobe_n) && protect_accelerate_pin);
  c_hw_reset: cover property ($rose(hw_reset_n));
endmodule
`default_nettype wire
